// >>> logic/pll_cfg_pkg.sv
// Shared constants and types for the synthesizer configuration logic
package pll_cfg_pkg;
  // Field widths
  localparam int M_W = 9;
  localparam int N_W = 2;
  localparam int T_W = 3;
  localparam int SR_W = 14;
  // Reference pre-divider ratio ahead of the phase comparison
  localparam int REF_DIV = 16;
  localparam int REF_CNT_W = 4;
  // Undriven divider pins read high through pull-ups
  localparam logic [M_W-1:0] M_PULLUP = 9'h1FF;
  localparam logic [N_W-1:0] N_PULLUP = 2'h3;
  localparam logic [T_W-1:0] T_QUIET = 3'h0;
  // Field positions in the serial word: test bits arrive first, so sit highest
  localparam int SR_T_LSB = 11;
  localparam int SR_N_LSB = 9;
  localparam int SR_M_LSB = 0;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SHIFT = 8'h08;
  // Field positions inside registers
  localparam int CTRL_OE_BIT = 0;
  localparam logic CTRL_OE_RST = 1'b1;
  localparam int STAT_N_LSB = 9;
  localparam int STAT_T_LSB = 11;
  localparam int STAT_PLOAD_BIT = 14;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  // Output divider select codes
  typedef enum logic [N_W-1:0] {
    NDIV_1 = 2'h0,
    NDIV_2 = 2'h1,
    NDIV_4 = 2'h2,
    NDIV_8 = 2'h3
  } ndiv_sel_t;
  // Test output node select codes
  typedef enum logic [T_W-1:0] {
    TM_QUIET = 3'h0,
    TM_REF = 3'h1,
    TM_FB = 3'h2,
    TM_VCO = 3'h3,
    TM_OUT = 3'h4,
    TM_XTAL = 3'h5,
    TM_SCLK = 3'h6,
    TM_MCNT = 3'h7
  } test_sel_t;
endpackage : pll_cfg_pkg

// >>> logic/cfg_link_if.sv
// Carrier between the configuration top, the shifter and the output divider
interface cfg_link_if;
  import pll_cfg_pkg::*;
  logic shift_tick;
  logic shift_bit;
  logic [SR_W-1:0] shift_word;
  logic vco_tick;
  logic vco_level;
  logic [N_W-1:0] n_sel;
  logic div_out;
  modport top (output shift_tick, output shift_bit, input shift_word,
               output vco_tick, output vco_level, output n_sel, input div_out);
  modport shifter (input shift_tick, input shift_bit, output shift_word);
  modport divider (input vco_tick, input vco_level, input n_sel, output div_out);
endinterface : cfg_link_if

// >>> logic/serial_shifter.sv
// Serial configuration shift register
module serial_shifter
  import pll_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link to the top
  cfg_link_if.shifter lnk
);
  logic [SR_W-1:0] sr_r;

  ////////////////////////////////////////////////////////////////////////////
  // One bit per shift clock rise, new bit enters at the bottom
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r <= '0;
    end else if (lnk.shift_tick) begin
      sr_r <= {sr_r[SR_W-2:0], lnk.shift_bit};
    end
  end

  assign lnk.shift_word = sr_r;
endmodule : serial_shifter

// >>> logic/out_divider.sv
// Output divider with even duty cycle
module out_divider
  import pll_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link to the top
  cfg_link_if.divider lnk
);
  logic [1:0] cnt_r;
  logic tog_r;
  logic out_r;
  logic [1:0] half_last;

  // Last count of a half period: toggling every half keeps 50 % duty
  function automatic logic [1:0] half_end(input logic [N_W-1:0] sel);
    unique case (ndiv_sel_t'(sel))
      NDIV_1: half_end = 2'h0;
      NDIV_2: half_end = 2'h0;
      NDIV_4: half_end = 2'h1;
      NDIV_8: half_end = 2'h3;
    endcase
  endfunction : half_end

  assign half_last = half_end(lnk.n_sel);

  ////////////////////////////////////////////////////////////////////////////
  // Half-period counter and toggle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
      tog_r <= 1'b0;
    end else if (lnk.vco_tick) begin
      if (cnt_r >= half_last) begin
        cnt_r <= 2'h0;
        tog_r <= ~tog_r;
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end

  // Divide by one passes the oscillator level itself
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else begin
      out_r <= (ndiv_sel_t'(lnk.n_sel) == NDIV_1) ? lnk.vco_level : tog_r;
    end
  end

  assign lnk.div_out = out_r;
endmodule : out_divider

// >>> logic/pll_synth_config_logic.sv
// Configuration logic of the PLL synthesizer: pins, serial link, dividers, bus
//
// What this block does
// - Crystal reference divided by sixteen before comparison
// - Feedback divider makes oscillator M times reference
// - Output divides by 1, 2, 4, 8, even duty
// - Parallel pins captured on load rising edge
// - Parallel load active blocks serial transfers
// - Undriven divider pins read as one
// - Fourteen-bit shifter advances on shift clock rise
// - Serial load falling edge transfers when load high
// - Test output shows node chosen by test bits
// - Loop divider is plain unsigned binary
// - Test mode six uses shift clock as test clock
// - Stream order: test, output, loop bits, MSB first
// - Parallel load low makes latches transparent
// - Parallel load low forces test bits to zero
// - Output select 00,01,10,11 means 1,2,4,8
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
module pll_synth_config_logic
  import pll_cfg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // Parallel configuration pins, with the far end's drive enables
  input wire logic p_load_n,
  input wire logic [M_W-1:0] m_pins,
  input wire logic [M_W-1:0] m_pins_drv,
  input wire logic [N_W-1:0] n_pins,
  input wire logic [N_W-1:0] n_pins_drv,
  // Serial configuration pins
  input wire logic s_clock,
  input wire logic s_data,
  input wire logic s_load,
  // Oscillator side
  input wire logic xtal_in,
  input wire logic vco_in,
  output logic phase_ref_tick,
  output logic phase_fb_tick,
  // Outputs
  output logic synth_clock_out,
  output logic test_out,
  output logic [M_W-1:0] loop_div,
  output logic [N_W-1:0] out_div_sel
);
  localparam int IN_W = 6 + M_W + N_W;
  localparam int B_SCLK = 0;
  localparam int B_SDAT = 1;
  localparam int B_SLOAD = 2;
  localparam int B_PLOAD = 3;
  localparam int B_XTAL = 4;
  localparam int B_VCO = 5;
  localparam int B_M = 6;
  localparam int B_N = 6 + M_W;
  // Synchroniser reset: divider pins at their pull-up level, every other pin low
  localparam logic [IN_W-1:0] SYNC_RST = IN_W'({N_PULLUP, M_PULLUP}) << B_M;

  // Only the low address byte is decoded, so narrower buses cannot be served
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end

  cfg_link_if lnk ();

  logic [IN_W-1:0] pin_raw;
  logic [IN_W-1:0] meta_r;
  logic [IN_W-1:0] sync_r;
  logic [5:0] prev_r;
  logic sclk_rise;
  logic sload_fall;
  logic pload_s;
  logic xtal_rise;
  logic vco_rise;
  logic test_clk_mode;
  logic osc_tick;
  logic [M_W-1:0] m_r;
  logic [N_W-1:0] n_r;
  logic [T_W-1:0] t_r;
  logic [REF_CNT_W-1:0] ref_cnt_r;
  logic [M_W-1:0] fb_cnt_r;
  logic ref_tick_r;
  logic fb_tick_r;
  logic oe_r;
  logic out_r;
  logic test_r;
  logic ph_valid_r;
  logic ph_write_r;
  logic [ADDR_W-1:0] ph_addr_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic addr_take;

  ////////////////////////////////////////////////////////////////////////////
  // Pin resolution: pull-ups win where the far end does not drive
  assign pin_raw[B_SCLK] = s_clock;
  assign pin_raw[B_SDAT] = s_data;
  assign pin_raw[B_SLOAD] = s_load;
  assign pin_raw[B_PLOAD] = p_load_n;
  assign pin_raw[B_XTAL] = xtal_in;
  assign pin_raw[B_VCO] = vco_in;
  assign pin_raw[B_M +: M_W] = (m_pins & m_pins_drv) | (M_PULLUP & ~m_pins_drv);
  assign pin_raw[B_N +: N_W] = (n_pins & n_pins_drv) | (N_PULLUP & ~n_pins_drv);

  // Two-stage synchroniser; reset levels (divider pins at pull-ups, load low) keep a reset with load high at pull-ups
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end else begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
    end
  end

  // Previous synchronised levels for edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= sync_r[5:0];
    end
  end

  assign sclk_rise = sync_r[B_SCLK] & ~prev_r[B_SCLK];
  assign sload_fall = ~sync_r[B_SLOAD] & prev_r[B_SLOAD];
  assign pload_s = sync_r[B_PLOAD];
  assign xtal_rise = sync_r[B_XTAL] & ~prev_r[B_XTAL];
  assign vco_rise = sync_r[B_VCO] & ~prev_r[B_VCO];

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter and output divider
  assign lnk.shift_tick = sclk_rise;
  assign lnk.shift_bit = sync_r[B_SDAT];

  // Test clock mode drives the feedback and output dividers from the shift clock instead
  assign test_clk_mode = (test_sel_t'(t_r) == TM_SCLK);
  assign osc_tick = test_clk_mode ? sclk_rise : vco_rise;
  assign lnk.vco_tick = osc_tick;
  assign lnk.vco_level = test_clk_mode ? sync_r[B_SCLK] : sync_r[B_VCO];
  assign lnk.n_sel = n_r;

  serial_shifter u_shifter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .lnk(lnk.shifter)
  );

  out_divider u_out_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .lnk(lnk.divider)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration latches: parallel first, serial only with load high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_r <= M_PULLUP;
      n_r <= N_PULLUP;
      t_r <= T_QUIET;
    end else if (!pload_s) begin
      // Transparent while low; the rising edge leaves the last value held
      m_r <= sync_r[B_M +: M_W];
      n_r <= sync_r[B_N +: N_W];
      t_r <= T_QUIET;
    end else if (sload_fall) begin
      m_r <= lnk.shift_word[SR_M_LSB +: M_W];
      n_r <= lnk.shift_word[SR_N_LSB +: N_W];
      t_r <= lnk.shift_word[SR_T_LSB +: T_W];
    end
    // Otherwise held, whatever the shifter does
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference pre-divider toward the phase comparison
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_r <= '0;
      ref_tick_r <= 1'b0;
    end else begin
      ref_tick_r <= 1'b0;
      if (xtal_rise) begin
        ref_cnt_r <= ref_cnt_r + 4'h1;
        ref_tick_r <= (ref_cnt_r == REF_CNT_W'(REF_DIV - 1));
      end
    end
  end

  // Feedback divider: one tick per M oscillator edges; zero divides by 512
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_cnt_r <= '0;
      fb_tick_r <= 1'b0;
    end else begin
      fb_tick_r <= 1'b0;
      if (osc_tick) begin
        if (fb_cnt_r >= m_r - 9'h001) begin
          fb_cnt_r <= '0;
          fb_tick_r <= 1'b1;
        end else begin
          fb_cnt_r <= fb_cnt_r + 9'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output gating and test node select
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else begin
      out_r <= oe_r & lnk.div_out;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_r <= 1'b0;
    end else begin
      unique case (test_sel_t'(t_r))
        TM_QUIET: test_r <= 1'b0;
        TM_REF: test_r <= ref_tick_r;
        TM_FB: test_r <= fb_tick_r;
        TM_VCO: test_r <= sync_r[B_VCO];
        TM_OUT: test_r <= lnk.div_out;
        TM_XTAL: test_r <= sync_r[B_XTAL];
        TM_SCLK: test_r <= fb_tick_r;
        TM_MCNT: test_r <= fb_cnt_r[M_W-1];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);

  // Address phase capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r <= '0;
    end else if (hready) begin
      ph_valid_r <= addr_take;
      ph_write_r <= hwrite;
      ph_addr_r <= haddr;
    end
  end

  // Control register write in the data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_r <= CTRL_OE_RST;
    end else if (ph_valid_r && ph_write_r && ph_addr_r[7:0] == ADDR_CTRL) begin
      oe_r <= hwdata[CTRL_OE_BIT];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      ADDR_CTRL: rd_mux[CTRL_OE_BIT] = oe_r;
      ADDR_STATUS: begin
        rd_mux[M_W-1:0] = m_r;
        rd_mux[STAT_N_LSB +: N_W] = n_r;
        rd_mux[STAT_T_LSB +: T_W] = t_r;
        rd_mux[STAT_PLOAD_BIT] = pload_s;
      end
      ADDR_SHIFT: rd_mux[SR_W-1:0] = lnk.shift_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address phase, stands through the data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      rdata_r <= rd_mux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdata_r;
  assign phase_ref_tick = ref_tick_r;
  assign phase_fb_tick = fb_tick_r;
  assign synth_clock_out = out_r;
  assign test_out = test_r;
  assign loop_div = m_r;
  assign out_div_sel = n_r;
endmodule : pll_synth_config_logic

// >>> tb/pll_synth_config_logic_asserts.sv
// Port-level checker for the synthesizer configuration logic
module pll_synth_config_logic_asserts
  import pll_cfg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic [31:0] hrdata,
  // Configuration pins
  input wire logic p_load_n,
  input wire logic [M_W-1:0] m_pins,
  input wire logic [M_W-1:0] m_pins_drv,
  input wire logic [N_W-1:0] n_pins,
  input wire logic [N_W-1:0] n_pins_drv,
  input wire logic s_clock,
  input wire logic s_data,
  input wire logic s_load,
  input wire logic xtal_in,
  // Outputs
  input wire logic phase_ref_tick,
  input wire logic test_out,
  input wire logic [M_W-1:0] loop_div,
  input wire logic [N_W-1:0] out_div_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rd_go;
  logic [M_W-1:0] m_eff;
  logic [N_W-1:0] n_eff;
  logic [SR_W-1:0] sr_r;
  logic sc_r;
  logic xt_r;
  logic seen_r;
  logic [5:0] xr_cnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Pin levels after the pull-ups, and a read address phase
  assign m_eff = (m_pins & m_pins_drv) | ~m_pins_drv;
  assign n_eff = (n_pins & n_pins_drv) | ~n_pins_drv;
  assign rd_go = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  // Shadow shifter; samples the raw pins without the synchroniser, so it shifts two cycles ahead of the design
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r <= '0;
      sc_r <= 1'b0;
    end else begin
      sc_r <= s_clock;
      if (s_clock && !sc_r) begin
        sr_r <= {sr_r[SR_W-2:0], s_data};
      end
    end
  end
  // Crystal rises between reference ticks; first tick only arms it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xt_r <= 1'b0;
      seen_r <= 1'b0;
      xr_cnt_r <= 6'h00;
    end else begin
      xt_r <= xtal_in;
      seen_r <= seen_r | phase_ref_tick;
      xr_cnt_r <= (phase_ref_tick ? 6'h00 : xr_cnt_r) + 6'(xtal_in && !xt_r);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_m_follow: assert property (
    (!p_load_n && $stable(m_eff))[*8] |-> loop_div == m_eff)
    else $error("loop divider not following pins");
  a_n_follow: assert property (
    (!p_load_n && $stable(n_eff))[*8] |-> out_div_sel == n_eff)
    else $error("output select not following pins");
  a_test_quiet: assert property ((!p_load_n)[*8] |-> !test_out)
    else $error("test output active during parallel load");
  a_cfg_hold: assert property (
    (p_load_n && !$fell(s_load))[*8] |-> $stable(loop_div) && $stable(out_div_sel))
    else $error("configuration moved without a load event");
  a_ser_load: assert property (
    $fell(s_load) && p_load_n |-> ##[1:8] loop_div == sr_r[8:0] && out_div_sel == sr_r[10:9])
    else $error("serial word not transferred");
  a_ref_div: assert property (phase_ref_tick && seen_r |-> xr_cnt_r == 6'h10)
    else $error("reference tick spacing wrong");
  a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus not ready or not okay");
  a_status_read: assert property (rd_go && haddr[7:0] == ADDR_STATUS |=>
    hrdata[10:0] == {$past(out_div_sel), $past(loop_div)} && hrdata[31:15] == '0)
    else $error("status read mismatch");
  a_unmapped_zero: assert property (rd_go && haddr[7:0] == 8'h0C |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  // Main scenarios reached
  c_ser_load: cover property ($fell(s_load) && p_load_n);
  c_ref_tick: cover property (phase_ref_tick && seen_r);
  c_status: cover property (rd_go && haddr[7:0] == ADDR_STATUS);
endmodule : pll_synth_config_logic_asserts

bind pll_synth_config_logic pll_synth_config_logic_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .p_load_n, .m_pins, .m_pins_drv, .n_pins, .n_pins_drv, .s_clock, .s_data, .s_load,
  .xtal_in, .phase_ref_tick, .test_out, .loop_div, .out_div_sel);

// >>> tb/cfg_ctrl_model.sv
// Controller model driving the parallel pins and the serial link
module cfg_ctrl_model
  import pll_cfg_pkg::*;
(
  // Parallel pins
  output logic p_load_n,
  output logic [M_W-1:0] m_pins,
  output logic [M_W-1:0] m_pins_drv,
  output logic [N_W-1:0] n_pins,
  output logic [N_W-1:0] n_pins_drv,
  // Serial link
  output logic s_clock,
  output logic s_data,
  output logic s_load
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////////
  // Power-up: load held low, pins floating
  initial begin
    p_load_n = 1'b0;
    {m_pins, m_pins_drv, n_pins, n_pins_drv} = '0;
    {s_clock, s_data, s_load} = 3'h0;
  end
  // Floating bits show 0 here, so only the pull-up logic can make them 1
  task automatic par_load(input logic [M_W-1:0] m, input logic [M_W-1:0] mdrv,
                          input logic [N_W-1:0] n, input bit keep_low);
    #1;
    p_load_n = 1'b0;
    m_pins = m & mdrv;
    m_pins_drv = mdrv;
    n_pins = n;
    n_pins_drv = 2'h3;
    #100;
    p_load_n = keep_low ? 1'b0 : 1'b1;
    #60;
  endtask : par_load
  // One frame, 80 ns link clock that stops between frames
  task automatic shift(input logic [SR_W-1:0] w, input bit load);
    #1;
    for (int i = SR_W - 1; i >= 0; i--) begin
      s_data = w[i];
      #20;
      s_clock = 1'b1;
      #40;
      s_clock = 1'b0;
      #20;
    end
    s_data = ~w[0];
    if (load) begin
      #20;
      s_load = 1'b1;
      #60;
      s_load = 1'b0;
      #60;
    end
  endtask : shift
endmodule : cfg_ctrl_model

// >>> tb/pll_synth_config_logic_bench.sv
// Self-checking bench for the synthesizer configuration logic
module pll_synth_config_logic_bench
  import pll_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic ser;
    logic [T_W-1:0] t;
    logic [N_W-1:0] n;
    logic [M_W-1:0] m;
    logic [M_W-1:0] mdrv;
  } row_t;
  // Loop values stay in the locking range
  row_t rows [4] = '{'{1'b0, 3'h0, 2'h0, 9'h0C8, 9'h1FF}, '{1'b0, 3'h0, 2'h1, 9'h000, 9'h0C8},
                     '{1'b1, 3'h0, 2'h2, 9'h106, 9'h1FF}, '{1'b1, 3'h5, 2'h3, 9'h190, 9'h1FF}};
  logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, xtal_in = 1'b0, vco_in = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0, hresp;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, p_load_n, s_clock, s_data, s_load;
  logic phase_ref_tick, phase_fb_tick, synth_clock_out, test_out;
  logic [M_W-1:0] m_pins, m_pins_drv, loop_div, exp_m;
  logic [N_W-1:0] n_pins, n_pins_drv, out_div_sel;
  int error_cnt = 0, n_compared = 0, cyc = 0, o_r, f_t, r_t, t_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Clocks: crystal 16 cycles, oscillator 8 cycles, both toggling on falling clock edges, neither on a rising one
  always #2.5 ref_clk = ~ref_clk;
  always #40 xtal_in = ~xtal_in;
  always #20 vco_in = ~vco_in;
  pll_synth_config_logic u_pll_synth_config_logic (.ref_clk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .p_load_n,
    .m_pins, .m_pins_drv, .n_pins, .n_pins_drv, .s_clock, .s_data, .s_load, .xtal_in, .vco_in,
    .phase_ref_tick, .phase_fb_tick, .synth_clock_out, .test_out, .loop_div, .out_div_sel);
  cfg_ctrl_model u_cfg_ctrl_model (.p_load_n, .m_pins, .m_pins_drv, .n_pins, .n_pins_drv,
    .s_clock, .s_data, .s_load);
  ////////////////////////////////////////////////////////////////////////////////
  // Single word transfer; waits on ready, read data taken at the data-phase edge
  task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                          output logic [31:0] d);
    @(posedge ref_clk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, a, HTRANS_NONSEQ, wr};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    d = hrdata;
  endtask : ahb_xfer
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Edge counts allow one edge of slack at the window ends
  task automatic near(input string what, input int exp, input int got);
    n_compared++;
    if (got > exp + 1 || got < exp - 1) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near
  task automatic measure();
    logic po, pt;
    {o_r, f_t, r_t, t_r} = '0;
    po = synth_clock_out;
    pt = test_out;
    repeat (3200) begin
      @(posedge ref_clk);
      #1;
      o_r += int'(synth_clock_out && !po);
      t_r += int'(test_out && !pt);
      f_t += int'(phase_fb_tick);
      r_t += int'(phase_ref_tick);
      po = synth_clock_out;
      pt = test_out;
    end
  endtask : measure
  task automatic test_done();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("m powerup", 32'h1FF, 32'(loop_div));
    chk("n powerup", 32'h3, 32'(out_div_sel));
    chk("test quiet", 32'h0, 32'(test_out));
    ahb_xfer(ADDR_CTRL, 1'b0, 32'h0, rd);
    chk("ctrl reset", 32'h1, rd);
    foreach (rows[i]) begin
      exp_m = (rows[i].m & rows[i].mdrv) | ~rows[i].mdrv;
      if (rows[i].ser) begin
        u_cfg_ctrl_model.shift({rows[i].t, rows[i].n, rows[i].m}, 1'b1);
      end else begin
        u_cfg_ctrl_model.par_load(rows[i].m, rows[i].mdrv, rows[i].n, 1'b0);
      end
      ahb_xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
      chk("status", {17'h0, 1'b1, rows[i].t, rows[i].n, exp_m}, rd);
      measure();
      near("out rises", 400 >> rows[i].n, o_r);
      near("fb ticks", 400 / int'(exp_m), f_t);
      near("ref ticks", 12, r_t);
      near("test rises", rows[i].t == 3'h5 ? 200 : 0, t_r);
    end
    // Test mode six: shift clock stands in for the oscillator, tiny M on purpose
    u_cfg_ctrl_model.shift({3'h6, 2'h0, 9'h002}, 1'b1);
    fork
      measure();
      u_cfg_ctrl_model.shift({3'h6, 2'h0, 9'h002}, 1'b0);
    join
    near("test clk out", 14, o_r);
    near("test clk fb", 7, f_t);
    near("test clk node", 7, t_r);
    // Load held low: pins flow through, serial frame and test bits kept out
    u_cfg_ctrl_model.par_load(9'h12C, 9'h1FF, 2'h2, 1'b1);
    chk("m follow", 32'h12C, 32'(loop_div));
    u_cfg_ctrl_model.shift({3'h5, 2'h3, 9'h0C8}, 1'b1);
    ahb_xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
    chk("blocked", {17'h0, 1'b0, 3'h0, 2'h2, 9'h12C}, rd);
    // Frame shifted with no strobe changes nothing but the shifter
    u_cfg_ctrl_model.par_load(9'h12C, 9'h1FF, 2'h2, 1'b0);
    u_cfg_ctrl_model.shift({3'h2, 2'h1, 9'h15E}, 1'b0);
    ahb_xfer(ADDR_SHIFT, 1'b0, 32'h0, rd);
    chk("shift reg", 32'({3'h2, 2'h1, 9'h15E}), rd);
    chk("held m", 32'h12C, 32'(loop_div));
    // Output gate off, unmapped and read-only writes ignored
    ahb_xfer(ADDR_CTRL, 1'b1, 32'h0, rd);
    measure();
    near("gated rises", 0, o_r);
    ahb_xfer(8'h0C, 1'b1, 32'hFFFFFFFF, rd);
    ahb_xfer(ADDR_STATUS, 1'b1, 32'hFFFFFFFF, rd);
    ahb_xfer(8'h0C, 1'b0, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    ahb_xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
    chk("status ro", {17'h0, 1'b1, 3'h0, 2'h2, 9'h12C}, rd);
    // Second reset in mid-run restores the gate
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    ahb_xfer(ADDR_CTRL, 1'b0, 32'h0, rd);
    chk("ctrl after reset", 32'h1, rd);
    chk("m after reset", 32'h1FF, 32'(loop_div));
    test_done();
  end
endmodule : pll_synth_config_logic_bench
